/* File: hmv_consts.svh */
// Constants of the homing and profile velocity control block.
// Assumes one 250 MHz drive clock; offsets are object dictionary indices.
`ifndef HMV_CONSTS_SVH
`define HMV_CONSTS_SVH
`define HMV_IDX_SENSOR 16'h6069
`define HMV_IDX_REF 16'h606b
`define HMV_IDX_MOTOR 16'h606c
`define HMV_IDX_BAND 16'h606d
`define HMV_IDX_WIN_MS 16'h606e
`define HMV_IDX_THR_BAND 16'h606f
`define HMV_IDX_THR_MS 16'h6070
`define HMV_IDX_CEIL 16'h607f
`define HMV_IDX_TARGET 16'h60ff
`define HMV_RST_BAND 16'h0014
`define HMV_RST_WIN_MS 16'h0000
`define HMV_RST_THR_BAND 16'h0032
`define HMV_RST_THR_MS 16'h0000
`define HMV_RST_CEIL 32'h0000_0000
`define HMV_RST_TARGET 32'h0000_0000
`define HMV_CTRL_HALT 8
`define HMV_STAT_REACHED 10
`define HMV_STAT_ZERO 12
`define HMV_STAT_SLIP 13
`define HMV_CLK_NS 4
`define HMV_MS_NS 1000000
`define HMV_MS_CYCLES (`HMV_MS_NS / `HMV_CLK_NS)
`endif

/* File: hmv_pkg.sv */
// Types of the homing and profile velocity control block.
// Assumes the constants header is included by the design file.
package hmv_pkg;
  typedef enum logic [2:0] {
    HMV_IDLE = 3'b000,
    HMV_LEG1 = 3'b001,
    HMV_LEG2 = 3'b010,
    HMV_INDEX = 3'b011,
    HMV_STALL = 3'b100
  } hmv_state_t;

  typedef struct packed {
    logic valid;
    logic two_leg;
    logic dir_pos;
    logic want_rise;
  } hmv_plan_t;

  typedef struct packed {
    logic [15:0] index;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } hmv_obj_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic ack;
    logic err;
  } hmv_obj_rsp_t;

  typedef struct packed {
    logic move;
    logic fast;
    logic dir_pos;
    logic done;
    logic err;
    logic [31:0] home_pos;
  } hmv_home_t;

  typedef struct packed {
    logic sw_s1;
    logic sw_s2;
    logic sw_p;
    logic ix_s1;
    logic ix_s2;
    logic ix_p;
    logic [31:0] tick_cnt;
    logic tick;
    hmv_state_t hstate;
    hmv_plan_t plan;
    logic stall_rev;
    hmv_home_t home;
    logic [16:0] win_cnt;
    logic [16:0] thr_cnt;
    logic [16:0] stall_cnt;
    logic reached;
    logic zero_spd;
    logic slip;
    logic [15:0] band;
    logic [15:0] win_ms;
    logic [15:0] thr_band;
    logic [15:0] thr_ms;
    logic [31:0] ceiling;
    logic [31:0] target;
    logic [31:0] demand;
    hmv_obj_rsp_t rsp;
  } hmv_st_t;
endpackage : hmv_pkg

/* File: hmv_ctrl.sv */
// Homing sequencer and profile velocity control for one servo axis.
// Assumes a fieldbus stack that turns object reads and writes into the
// index port here, and a speed loop that follows speed_ref.
`timescale 1ns/1ps
`include "hmv_consts.svh"
module hmv_ctrl #(
  parameter int MS_CYCLES = `HMV_MS_CYCLES,
  parameter logic [31:0] RAMP_STEP = 32'h0000_0010
) (
  input wire logic clk,
  input wire logic rst,
  input wire hmv_pkg::hmv_obj_req_t obj_req,
  output hmv_pkg::hmv_obj_rsp_t obj_rsp,
  input wire logic [15:0] control_word,
  input wire logic velocity_mode_en,
  input wire logic home_start,
  input wire logic signed [7:0] home_method,
  input wire logic home_switch,
  input wire logic index_pulse,
  input wire logic signed [15:0] torque_now,
  input wire logic [15:0] stall_torque_setting,
  input wire logic [15:0] stall_dwell_setting,
  input wire logic [31:0] position_now,
  input wire logic signed [31:0] sensor_speed_in,
  input wire logic signed [31:0] motor_speed_in,
  input wire logic slip_limit_flag,
  output logic [15:0] status_word,
  output logic signed [31:0] speed_ref,
  output hmv_pkg::hmv_home_t home
);
  import hmv_pkg::*;

  hmv_st_t st_q;
  hmv_st_t st_d;

  // Only the switch methods that reach home on an edge are planned here.
  function automatic hmv_plan_t plan_of(input logic signed [7:0] m,
                                        input logic sw);
    hmv_plan_t p;
    p = '0;
    p.valid = 1'b1;
    case (m)
      8'sd19: p = sw ? 4'b1000 : 4'b1111;
      8'sd20: p = sw ? 4'b1100 : 4'b1011;
      8'sd21: p = sw ? 4'b1010 : 4'b1101;
      8'sd22: p = sw ? 4'b1110 : 4'b1001;
      default: p = '0;
    endcase
    return p;
  endfunction : plan_of

  function automatic logic [32:0] abs33(input logic signed [32:0] v);
    return v[32] ? 33'(-v) : v;
  endfunction : abs33

  logic rise;
  logic fall;
  logic edge_hit;
  logic stalled;
  logic [32:0] err_abs;
  logic [32:0] spd_abs;
  logic [32:0] lim;
  logic signed [32:0] goal;
  logic signed [32:0] ramp;
  logic halt;
  logic signed [32:0] ramp_step;

  assign halt = control_word[`HMV_CTRL_HALT];
  // An unsigned step would make the ramp compares unsigned and walk a
  // resting reference below zero.
  assign ramp_step = signed'({1'b0, RAMP_STEP});
  assign rise = st_q.sw_s2 & ~st_q.sw_p;
  assign fall = ~st_q.sw_s2 & st_q.sw_p;
  assign edge_hit = st_q.plan.want_rise ? rise : fall;
  assign stalled = st_q.stall_cnt >= {1'b0, stall_dwell_setting};
  assign err_abs = abs33(33'(motor_speed_in) - 33'(signed'(st_q.target)));
  assign spd_abs = abs33(33'(motor_speed_in));
  // A ceiling above the signed range cannot limit a signed reference.
  assign lim = st_q.ceiling[31] ? 33'h0_7fff_ffff : {1'b0, st_q.ceiling};

  always_comb
  begin
    st_d = st_q;
    goal = '0;
    ramp = '0;
    st_d.rsp.ack = 1'b0;
    st_d.rsp.err = 1'b0;
    // The first stages feed only the second stages.
    st_d.sw_s1 = home_switch;
    st_d.sw_s2 = st_q.sw_s1;
    st_d.sw_p = st_q.sw_s2;
    st_d.ix_s1 = index_pulse;
    st_d.ix_s2 = st_q.ix_s1;
    st_d.ix_p = st_q.ix_s2;

    st_d.tick = 1'b0;
    if (st_q.tick_cnt >= 32'(MS_CYCLES - 1))
    begin
      st_d.tick_cnt = '0;
      st_d.tick = 1'b1;
    end
    else
    begin
      st_d.tick_cnt = st_q.tick_cnt + 32'h1;
    end

    // Window and threshold timers restart when leaving their bands; the stall timer restarts below the stall torque or outside HMV_STALL.
    if (err_abs >= {17'h0, st_q.band})
      st_d.win_cnt = '0;
    else if (st_q.tick && !st_q.win_cnt[16])
      st_d.win_cnt = st_q.win_cnt + 17'h1;
    if (spd_abs >= {17'h0, st_q.thr_band})
      st_d.thr_cnt = '0;
    else if (st_q.tick && !st_q.thr_cnt[16])
      st_d.thr_cnt = st_q.thr_cnt + 17'h1;
    if (st_q.hstate != HMV_STALL ||
        abs33(33'(torque_now)) < {17'h0, stall_torque_setting})
      st_d.stall_cnt = '0;
    else if (st_q.tick && !st_q.stall_cnt[16])
      st_d.stall_cnt = st_q.stall_cnt + 17'h1;

    // Halt turns target reached into an at-rest indication.
    if (halt)
      st_d.reached = motor_speed_in == 32'sh0;
    else
      st_d.reached = err_abs < {17'h0, st_q.band} &&
                     st_d.win_cnt >= {1'b0, st_q.win_ms};
    st_d.zero_spd = spd_abs < {17'h0, st_q.thr_band} &&
                    st_q.thr_cnt > {1'b0, st_q.thr_ms};
    st_d.slip = slip_limit_flag;

    // The ramp stands in for the profile generator; halt ramps to zero.
    if (velocity_mode_en && !halt)
      goal = 33'(signed'(st_q.target));
    if (goal > signed'(lim))
      goal = signed'(lim);
    else if (goal < -signed'(lim))
      goal = -signed'(lim);
    ramp = 33'(signed'(st_q.demand));
    if (goal > ramp + ramp_step)
      ramp = ramp + ramp_step;
    else if (goal < ramp - ramp_step)
      ramp = ramp - ramp_step;
    else
      ramp = goal;
    if (ramp > signed'(lim))
      ramp = signed'(lim);
    else if (ramp < -signed'(lim))
      ramp = -signed'(lim);
    st_d.demand = ramp[31:0];

    case (st_q.hstate)
      HMV_IDLE:
      begin
        if (home_start)
        begin
          st_d.home.done = 1'b0;
          st_d.home.err = 1'b0;
          st_d.home.fast = 1'b0;
          st_d.plan = plan_of(home_method, st_q.sw_s2);
          st_d.stall_rev = home_method == -8'sd4 || home_method == -8'sd3;
          case (home_method)
            8'sd35:
            begin
              st_d.home.home_pos = position_now;
              st_d.home.done = 1'b1;
            end
            8'sd33, 8'sd34:
            begin
              st_d.home.move = 1'b1;
              st_d.home.dir_pos = home_method == 8'sd34;
              st_d.hstate = HMV_INDEX;
            end
            -8'sd1, -8'sd2, -8'sd3, -8'sd4:
            begin
              st_d.home.move = 1'b1;
              st_d.home.dir_pos = home_method == -8'sd2 ||
                                  home_method == -8'sd4;
              st_d.hstate = HMV_STALL;
            end
            default:
            begin
              if (st_d.plan.valid)
              begin
                st_d.home.move = 1'b1;
                st_d.home.fast = st_d.plan.two_leg;
                st_d.home.dir_pos = st_d.plan.dir_pos;
                st_d.hstate = st_d.plan.two_leg ? HMV_LEG1 : HMV_LEG2;
              end
              else
              begin
                st_d.home.err = 1'b1;
              end
            end
          endcase
        end
      end
      HMV_LEG1:
      begin
        if (edge_hit)
        begin
          st_d.home.fast = 1'b0;
          st_d.home.dir_pos = ~st_q.home.dir_pos;
          st_d.plan.want_rise = ~st_q.plan.want_rise;
          st_d.hstate = HMV_LEG2;
        end
      end
      HMV_LEG2:
      begin
        if (edge_hit)
        begin
          st_d.home.home_pos = position_now;
          st_d.home.move = 1'b0;
          st_d.home.done = 1'b1;
          st_d.hstate = HMV_IDLE;
        end
      end
      HMV_INDEX:
      begin
        if (st_q.ix_s2 && !st_q.ix_p)
        begin
          st_d.home.home_pos = position_now;
          st_d.home.move = 1'b0;
          st_d.home.done = 1'b1;
          st_d.hstate = HMV_IDLE;
        end
      end
      HMV_STALL:
      begin
        if (stalled && st_q.stall_rev)
        begin
          st_d.home.dir_pos = ~st_q.home.dir_pos;
          st_d.hstate = HMV_INDEX;
        end
        else if (stalled)
        begin
          st_d.home.home_pos = position_now;
          st_d.home.move = 1'b0;
          st_d.home.done = 1'b1;
          st_d.hstate = HMV_IDLE;
        end
      end
      default:
      begin
        st_d.hstate = HMV_IDLE;
      end
    endcase

    // Writes to read-only or unknown objects are refused with err.
    if (obj_req.wr || obj_req.rd)
    begin
      st_d.rsp.ack = 1'b1;
      st_d.rsp.rdata = '0;
      case (obj_req.index)
        `HMV_IDX_SENSOR: st_d.rsp.rdata = sensor_speed_in;
        `HMV_IDX_REF: st_d.rsp.rdata = st_q.demand;
        `HMV_IDX_MOTOR: st_d.rsp.rdata = motor_speed_in;
        `HMV_IDX_BAND: st_d.rsp.rdata = {16'h0, st_q.band};
        `HMV_IDX_WIN_MS: st_d.rsp.rdata = {16'h0, st_q.win_ms};
        `HMV_IDX_THR_BAND: st_d.rsp.rdata = {16'h0, st_q.thr_band};
        `HMV_IDX_THR_MS: st_d.rsp.rdata = {16'h0, st_q.thr_ms};
        `HMV_IDX_CEIL: st_d.rsp.rdata = st_q.ceiling;
        `HMV_IDX_TARGET: st_d.rsp.rdata = st_q.target;
        default: st_d.rsp.err = 1'b1;
      endcase
      if (obj_req.wr)
      begin
        case (obj_req.index)
          `HMV_IDX_BAND: st_d.band = obj_req.wdata[15:0];
          `HMV_IDX_WIN_MS: st_d.win_ms = obj_req.wdata[15:0];
          `HMV_IDX_THR_BAND: st_d.thr_band = obj_req.wdata[15:0];
          `HMV_IDX_THR_MS: st_d.thr_ms = obj_req.wdata[15:0];
          `HMV_IDX_CEIL: st_d.ceiling = obj_req.wdata;
          `HMV_IDX_TARGET: st_d.target = obj_req.wdata;
          default: st_d.rsp.err = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= '0;
      st_q.band <= `HMV_RST_BAND;
      st_q.win_ms <= `HMV_RST_WIN_MS;
      st_q.thr_band <= `HMV_RST_THR_BAND;
      st_q.thr_ms <= `HMV_RST_THR_MS;
      st_q.ceiling <= `HMV_RST_CEIL;
      st_q.target <= `HMV_RST_TARGET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  always_comb
  begin
    status_word = '0;
    status_word[`HMV_STAT_REACHED] = st_q.reached;
    status_word[`HMV_STAT_ZERO] = st_q.zero_spd;
    status_word[`HMV_STAT_SLIP] = st_q.slip;
  end
  assign speed_ref = st_q.demand;
  assign home = st_q.home;
  assign obj_rsp = st_q.rsp;

  a_present_home: assert property (@(posedge clk) disable iff (rst)
    st_q.hstate == HMV_IDLE && home_start && home_method == 8'sd35
    |=> home.done && !home.move && home.home_pos == $past(position_now))
    else $error("present position not adopted");
  a_index_stop: assert property (@(posedge clk) disable iff (rst)
    st_q.hstate == HMV_INDEX && st_q.ix_s2 && !st_q.ix_p
    |=> home.done && !home.move ##1 !home.move)
    else $error("index pulse did not stop homing");
  a_edge_stop: assert property (@(posedge clk) disable iff (rst)
    st_q.hstate == HMV_LEG2 && edge_hit
    |=> home.done && home.home_pos == $past(position_now))
    else $error("switch edge did not set home");
  a_leg_turn: assert property (@(posedge clk) disable iff (rst)
    st_q.hstate == HMV_LEG1 && edge_hit
    |=> !home.fast && home.dir_pos != $past(home.dir_pos))
    else $error("first leg did not reverse slowly");
  a_halt_moving: assert property (@(posedge clk) disable iff (rst)
    halt && motor_speed_in != 32'sh0
    |=> !status_word[`HMV_STAT_REACHED])
    else $error("reached shown while decelerating");
  a_window_leave: assert property (@(posedge clk) disable iff (rst)
    !halt && err_abs >= {17'h0, st_q.band}
    |=> !status_word[`HMV_STAT_REACHED] && st_q.win_cnt == 17'h0)
    else $error("reached held outside window");
  a_zero_leave: assert property (@(posedge clk) disable iff (rst)
    spd_abs >= {17'h0, st_q.thr_band}
    |=> !status_word[`HMV_STAT_ZERO] && st_q.thr_cnt == 17'h0)
    else $error("zero speed held above threshold");
  a_slip_follow: assert property (@(posedge clk) disable iff (rst)
    slip_limit_flag |=> status_word[`HMV_STAT_SLIP] ##0
    $past(slip_limit_flag))
    else $error("slippage flag not reported");
  a_ceiling_hold: assert property (@(posedge clk) disable iff (rst)
    $past(lim) == lim |-> abs33(33'(speed_ref)) <= lim)
    else $error("speed reference above ceiling");
endmodule : hmv_ctrl

/* File: hmv_master_model.sv */
// Fieldbus master model that reads and writes drive objects.
// Assumes the drive answers each one-cycle strobe on the next edge.
`timescale 1ns/1ps
module hmv_master_model (
  input wire logic clk,
  output hmv_pkg::hmv_obj_req_t obj_req,
  input wire hmv_pkg::hmv_obj_rsp_t obj_rsp
);
  import hmv_pkg::*;
  logic [31:0] rdata;
  logic ack;
  logic err;
  initial obj_req = '0;
  // Idle index and data are inverted so a stale value never looks fresh.
  task automatic access(input logic [15:0] idx, input logic wr,
                        input logic [31:0] wd);
    obj_req.index = idx;
    obj_req.wdata = wd; // Signed speeds travel whole.
    obj_req.wr = wr;
    obj_req.rd = ~wr;
    @(posedge clk);
    #1;
    obj_req.wr = 1'b0;
    obj_req.rd = 1'b0;
    obj_req.index = ~idx;
    obj_req.wdata = ~wd;
    rdata = obj_rsp.rdata;
    ack = obj_rsp.ack;
    err = obj_rsp.err;
    // A spare edge keeps a following call from raising a strobe at once.
    @(posedge clk);
    #1;
  endtask : access
endmodule : hmv_master_model

/* File: test_homing_and_velocity_mode_control.sv */
// Self-checking bench for the homing and velocity control block.
// Assumes a shortened millisecond of 10 cycles at a 4 ns clock.
`timescale 1ns/1ps
module test_homing_and_velocity_mode_control;
  import hmv_pkg::*;
  logic clk, rst, home_start, home_switch, index_pulse, slip_flag, vel_en;
  logic [15:0] control_word, stall_torque, stall_dwell, status_word;
  logic signed [7:0] home_method;
  logic signed [15:0] torque_now;
  logic [31:0] position_now;
  logic signed [31:0] sensor_speed, motor_speed, speed_ref;
  hmv_obj_req_t obj_req;
  hmv_obj_rsp_t obj_rsp;
  hmv_home_t home;
  int failures, comparisons;

  hmv_ctrl #(.MS_CYCLES(10)) hmv_ctrl_inst (.clk(clk), .rst(rst),
    .obj_req(obj_req), .obj_rsp(obj_rsp), .control_word(control_word),
    .velocity_mode_en(vel_en), .home_start(home_start),
    .home_method(home_method), .home_switch(home_switch),
    .index_pulse(index_pulse), .torque_now(torque_now),
    .stall_torque_setting(stall_torque),
    .stall_dwell_setting(stall_dwell), .position_now(position_now),
    .sensor_speed_in(sensor_speed), .motor_speed_in(motor_speed),
    .slip_limit_flag(slip_flag), .status_word(status_word),
    .speed_ref(speed_ref), .home(home));
  hmv_master_model hmv_master_model_inst (.clk(clk), .obj_req(obj_req),
    .obj_rsp(obj_rsp));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    hmv_master_model_inst.access(idx, 1'b1, wd);
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [31:0] want);
    hmv_master_model_inst.access(idx, 1'b0, 32'h0);
    check(hmv_master_model_inst.ack, 1'b1);
    check(hmv_master_model_inst.rdata, want);
  endtask : rd

  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic t_objects;
    rd(16'h606d, 32'h14);
    rd(16'h606e, 32'h0);
    rd(16'h606f, 32'h32);
    rd(16'h6070, 32'h0);
    rd(16'h607f, 32'h0);
    rd(16'h60ff, 32'h0);
    rd(16'h6069, 32'hffff_fb2e);
    rd(16'h606c, 32'h0000_0000);
    wr(16'h6069, 32'h5);
    check(hmv_master_model_inst.err, 1'b1);
    rd(16'h6069, 32'hffff_fb2e);
    hmv_master_model_inst.access(16'h6000, 1'b0, 32'h0);
    check(hmv_master_model_inst.err, 1'b1);
    wr(16'h606d, 32'habcd_0019);
    rd(16'h606d, 32'h19);
    $display("finished objects");
  endtask : t_objects

  task automatic t_velocity;
    wr(16'h607f, 32'h100);
    wr(16'h60ff, 32'h200);
    step(60);
    check(speed_ref, 32'h100);
    rd(16'h606b, 32'h100);
    check(status_word[10], 1'b0);
    motor_speed = 32'h1f0;
    step(3);
    check(status_word[10], 1'b1);
    motor_speed = 32'h1e0;
    step(3);
    check(status_word[10], 1'b0);
    wr(16'h606e, 32'h2);
    motor_speed = 32'h1f0;
    step(8);
    check(status_word[10], 1'b0);
    step(25);
    check(status_word[10], 1'b1);
    control_word = 16'h0100;
    motor_speed = 32'h5;
    step(3);
    check(status_word[10], 1'b0);
    motor_speed = 32'h0;
    step(3);
    check(status_word[10], 1'b1);
    step(20);
    check(speed_ref, 32'h0);
    control_word = 16'h0000;
    step(20);
    check(speed_ref, 32'h100);
    wr(16'h60ff, 32'hffff_fe00);
    step(40);
    check(speed_ref, 32'hffff_ff00);
    vel_en = 1'b0;
    step(40);
    check(speed_ref, 32'h0);
    vel_en = 1'b1;
    $display("finished velocity");
  endtask : t_velocity

  task automatic t_flags;
    motor_speed = 32'h40;
    wr(16'h6070, 32'h1);
    step(3);
    check(status_word[12], 1'b0);
    motor_speed = 32'h20;
    step(5);
    check(status_word[12], 1'b0);
    step(30);
    check(status_word[12], 1'b1);
    motor_speed = 32'hffff_ffe0;
    step(3);
    check(status_word[12], 1'b1);
    motor_speed = 32'h40;
    step(2);
    check(status_word[12], 1'b0);
    slip_flag = 1'b1;
    step(2);
    check(status_word[13], 1'b1);
    slip_flag = 1'b0;
    step(2);
    check(status_word[13], 1'b0);
    $display("finished flags");
  endtask : t_flags

  task automatic start(input logic signed [7:0] m, input logic dir);
    position_now = 32'h0000_1000 + 32'(m);
    home_method = m;
    home_start = 1'b1;
    step(1);
    home_start = 1'b0;
    step(2);
    check({home.move, home.dir_pos, home.err}, {1'b1, dir, 1'b0});
  endtask : start

  task automatic finish_check;
    check({home.move, home.done}, 2'b01);
    check(home.home_pos, position_now);
  endtask : finish_check

  task automatic t_switch(input logic signed [7:0] m, input logic sw,
                          input logic fast, input logic dir, input logic two);
    home_switch = sw;
    step(4);
    start(m, dir);
    check(home.fast, fast);
    if (two)
    begin
      home_switch = ~sw;
      step(5);
      check({home.move, home.fast, home.dir_pos}, {2'b10, ~dir});
    end
    home_switch = ~home_switch;
    step(5);
    finish_check();
  endtask : t_switch

  task automatic t_index(input logic signed [7:0] m, input logic dir);
    start(m, dir);
    check(home.fast, 1'b0);
    index_pulse = 1'b1;
    step(2);
    index_pulse = 1'b0;
    step(4);
    finish_check();
  endtask : t_index

  task automatic t_stall(input logic signed [7:0] m, input logic dir,
                         input logic idx);
    start(m, dir);
    torque_now = 16'hff00;
    step(5);
    check(home.done, 1'b0);
    step(40);
    torque_now = 16'h0000;
    if (idx)
    begin
      check({home.move, home.dir_pos}, {1'b1, ~dir});
      index_pulse = 1'b1;
      step(2);
      index_pulse = 1'b0;
      step(4);
    end
    finish_check();
  endtask : t_stall

  task automatic t_homing;
    // The switch level is flipped by the caller to pick the branch.
    t_switch(8'sd21, 1'b1, 1'b0, 1'b1, 1'b0);
    t_switch(8'sd21, 1'b0, 1'b1, 1'b0, 1'b1);
    t_switch(8'sd22, 1'b1, 1'b1, 1'b1, 1'b1);
    t_switch(8'sd22, 1'b0, 1'b0, 1'b0, 1'b0);
    t_switch(8'sd19, 1'b0, 1'b1, 1'b1, 1'b1);
    t_switch(8'sd20, 1'b1, 1'b1, 1'b0, 1'b1);
    t_index(8'sd33, 1'b0);
    t_index(8'sd34, 1'b1);
    home_method = 8'sd35;
    home_start = 1'b1;
    step(1);
    home_start = 1'b0;
    step(1);
    finish_check();
    t_stall(-8'sd4, 1'b1, 1'b1);
    t_stall(-8'sd3, 1'b0, 1'b1);
    t_stall(-8'sd2, 1'b1, 1'b0);
    t_stall(-8'sd1, 1'b0, 1'b0);
    home_method = 8'sd5;
    home_start = 1'b1;
    step(1);
    home_start = 1'b0;
    step(2);
    check({home.move, home.err}, 2'b01);
    $display("finished homing");
  endtask : t_homing

  initial
  begin
    rst = 1'b1;
    control_word = 16'h0000;
    home_start = 1'b0;
    home_switch = 1'b0;
    index_pulse = 1'b0;
    slip_flag = 1'b0;
    vel_en = 1'b1;
    home_method = 8'sd0;
    torque_now = 16'h0000;
    stall_torque = 16'h0080;
    stall_dwell = 16'h0002;
    position_now = 32'h0;
    sensor_speed = 32'hffff_fb2e;
    motor_speed = 32'h0;
    failures = 0;
    comparisons = 0;
    step(5);
    rst = 1'b0;
    t_objects();
    t_velocity();
    t_flags();
    t_homing();
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end
endmodule : test_homing_and_velocity_mode_control
